// [uib_consts.svh]
// offsets, field positions, widths and timing counts of the serial port block
//------------------------------------------------------------
// Function
// [R1] tx level flag when occupancy at or below threshold
// [R2] rx level flag when occupancy at or above threshold
// [R3] overrun flag when character arrives while full
// [R4] flag every clear-to-send change under flow control
// [R5] flag parity mismatch and missing start/stop bit
// [R6] timeout flag when data sits idle too long
// [R7] separate flags for first and last break
// [R8] prescale clock by two to seven-minus-select
// [R9] integer divisor is whole part of bit period
// [R10] fraction divisor counts in 128ths
// [R11] software picks largest prescale keeping divisor one
// [R12] 32-byte fifos each way with own request
// [R13] transfer requests independent, enabled, occupancy driven
// [R14] rx request when count exceeds rx level
// [R15] software keeps rx level below 32
// [R16] tx request when count falls below tx level
// [R17] software keeps tx level above one
// [R18] flush bits empty each fifo independently
// [R19] clearing enable flushes both fifos
// [R20] flow enable gives hardware rts/cts with polarity
// [R21] wait for cts, finish current character
// [R22] rts drops at stop threshold, returns below
// [R23] idle frame limit zero means 256 frames
// [R24] polarity zero asserts low, one asserts high
// [R25] without flow control ignore cts, rts fixed
//------------------------------------------------------------
`ifndef UIB_CONSTS_SVH
`define UIB_CONSTS_SVH
`define UIB_OFS_CTRL0 6'h00
`define UIB_OFS_CTRL1 6'h04
`define UIB_OFS_STAT 6'h08
`define UIB_OFS_FLAGS 6'h10
`define UIB_OFS_RATE_INT 6'h14
`define UIB_OFS_RATE_FRAC 6'h18
`define UIB_OFS_DATA 6'h1c
`define UIB_OFS_XFER 6'h20
`define UIB_C0_EN 0
`define UIB_C0_PAR_EN 1
`define UIB_C0_PAR_ODD 2
`define UIB_C0_BRK 3
`define UIB_C0_RXFL 4
`define UIB_C0_TXFL 5
`define UIB_C0_FLOW 11
`define UIB_C0_FPOL 12
`define UIB_C0_LIM_LSB 16
`define UIB_FLAG_W 9
`define UIB_FRAME_BITS 4'd10
`define UIB_LIMIT_ZERO 9'h100
`define UIB_FRAC_STEP 8'h80
`endif

// [uib_pkg.sv]
// types shared by the serial port block
package uib_pkg;
   typedef enum logic [2:0] {
      UIB_IDLE = 3'b000,
      UIB_START = 3'b001,
      UIB_DATA = 3'b011,
      UIB_PAR = 3'b010,
      UIB_STOP = 3'b110
   } uib_state_t;
   typedef struct packed {
      logic brk_last;
      logic brk_first;
      logic timeout;
      logic frame;
      logic parity;
      logic cts;
      logic overrun;
      logic rx_lvl;
      logic tx_lvl;
   } uib_flags_t;
endpackage

// [uib_top.sv]
// serial port with fractional rate, fifo transfer requests and rts/cts flow control
`timescale 1ns/1ns
`include "uib_consts.svh"
module uib_top #(
   parameter int AW = 5,
   parameter int IW = 12
) (
   input wire logic clk, // 100 MHz clock
   input wire logic sys_rst, // async reset, active high
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // low for the completing cycle
   input wire logic rxd_in, // serial receive pin
   input wire logic cts_in, // clear-to-send pin
   output logic txd_out, // serial transmit pin
   output logic rts_out, // request-to-send pin
   output logic tx_dma_req, // tx fifo wants filling
   output logic rx_dma_req // rx fifo wants draining
);
   import uib_pkg::*;
   localparam int DEPTH = 2 ** AW;
   localparam int DW = IW + 8;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic en_r, par_en_r, par_odd_r, brk_r, flow_r, fpol_r;
   logic [7:0] idle_frame_limit_r;
   logic [AW:0] rx_thr_r, tx_thr_r, rts_lvl_r, txdma_lvl_r, rxdma_lvl_r;
   logic txdma_en_r, rxdma_en_r;
   logic [2:0] presc_sel_r;
   logic [IW-1:0] ibaud_r;
   logic [6:0] dbaud_r;
   uib_flags_t flags_r, set_v;
   logic [31:0] rd_mux;
   logic [5:0] wa;
   logic wr, rd;

   //------------------------------------------------------------
   // register bus slave
   //------------------------------------------------------------
   assign wa = {avs_address[5:2], 2'b00};
   assign wr = avs_write & ~avs_waitrequest;
   assign rd = avs_read & ~avs_waitrequest;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_mux : 32'h0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {en_r, par_en_r, par_odd_r, brk_r, flow_r, fpol_r} <= 6'h0;
         idle_frame_limit_r <= 8'h0;
         {rx_thr_r, tx_thr_r, rts_lvl_r} <= 18'h0;
         {txdma_lvl_r, rxdma_lvl_r, txdma_en_r, rxdma_en_r} <= 14'h0;
         presc_sel_r <= 3'h0;
         ibaud_r <= '0;
         dbaud_r <= 7'h0;
      end else if (wr) begin
         unique case (wa)
            `UIB_OFS_CTRL0: begin
               en_r <= avs_writedata[`UIB_C0_EN];
               par_en_r <= avs_writedata[`UIB_C0_PAR_EN];
               par_odd_r <= avs_writedata[`UIB_C0_PAR_ODD];
               brk_r <= avs_writedata[`UIB_C0_BRK];
               flow_r <= avs_writedata[`UIB_C0_FLOW];
               fpol_r <= avs_writedata[`UIB_C0_FPOL];
               idle_frame_limit_r <= avs_writedata[`UIB_C0_LIM_LSB +: 8];
            end
            `UIB_OFS_CTRL1: begin
               rx_thr_r <= avs_writedata[AW:0];
               tx_thr_r <= avs_writedata[8 +: AW + 1];
               rts_lvl_r <= avs_writedata[16 +: AW + 1];
            end
            `UIB_OFS_RATE_INT: begin
               ibaud_r <= avs_writedata[IW-1:0];
               presc_sel_r <= avs_writedata[18:16];
            end
            `UIB_OFS_RATE_FRAC: dbaud_r <= avs_writedata[6:0];
            `UIB_OFS_XFER: begin
               txdma_lvl_r <= avs_writedata[AW:0];
               txdma_en_r <= avs_writedata[7];
               rxdma_lvl_r <= avs_writedata[8 +: AW + 1];
               rxdma_en_r <= avs_writedata[15];
            end
            default: ;
         endcase
      end
   end

   //------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------
   logic cts_s1, cts_s2, cts_q, rxd_s1, rxd_s2, rxd_q, cts_ok;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {cts_s1, cts_s2, cts_q, rxd_s1, rxd_s2, rxd_q} <= 6'h3f;
      end else begin
         {cts_s1, cts_s2, cts_q} <= {cts_in, cts_s1, cts_s2};
         {rxd_s1, rxd_s2, rxd_q} <= {rxd_in, rxd_s1, rxd_s2};
      end
   end
   assign cts_ok = ~flow_r | (cts_s2 == fpol_r); // R20 R24 R25

   //------------------------------------------------------------
   // fifos
   //------------------------------------------------------------
   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [AW:0] tx_cnt, rx_cnt;
   logic tx_push, tx_pop, tx_clr, rx_push, rx_pop, rx_clr, rx_done;
   logic [7:0] rx_sh_r;

   assign tx_push = wr & (wa == `UIB_OFS_DATA) & (tx_cnt != FULL);
   assign rx_pop = rd & (wa == `UIB_OFS_DATA) & (rx_cnt != '0);
   assign rx_push = rx_done & (rx_cnt != FULL);
   assign tx_clr = ~en_r | (wr & (wa == `UIB_OFS_CTRL0) & avs_writedata[`UIB_C0_TXFL]); // R18 R19
   assign rx_clr = ~en_r | (wr & (wa == `UIB_OFS_CTRL0) & avs_writedata[`UIB_C0_RXFL]); // R18 R19

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {tx_wp, tx_rp, tx_cnt} <= '0;
      end else if (tx_clr) begin
         {tx_wp, tx_rp, tx_cnt} <= '0;
      end else begin
         if (tx_push) tx_wp <= tx_wp + 1'b1;
         if (tx_pop) tx_rp <= tx_rp + 1'b1;
         if (tx_push & ~tx_pop) tx_cnt <= tx_cnt + 1'b1;
         else if (~tx_push & tx_pop) tx_cnt <= tx_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {rx_wp, rx_rp, rx_cnt} <= '0;
      end else if (rx_clr) begin
         {rx_wp, rx_rp, rx_cnt} <= '0;
      end else begin
         if (rx_push) rx_wp <= rx_wp + 1'b1;
         if (rx_pop) rx_rp <= rx_rp + 1'b1;
         if (rx_push & ~rx_pop) rx_cnt <= rx_cnt + 1'b1;
         else if (~rx_push & rx_pop) rx_cnt <= rx_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (tx_push) tx_mem[tx_wp] <= avs_writedata[7:0];
      if (rx_push) rx_mem[rx_wp] <= rx_sh_r;
   end

   //------------------------------------------------------------
   // bit-rate generator
   //------------------------------------------------------------
   logic [6:0] presc_cnt, presc_max;
   logic presc_tick, tx_tick, rx_tick, rx_start;
   logic [DW-1:0] div, tx_acc, rx_acc, tx_sum, rx_sum;
   assign presc_max = 7'h7f >> presc_sel_r; // R8
   assign presc_tick = presc_cnt >= presc_max;
   assign div = {1'b0, ibaud_r, dbaud_r}; // R9 R10
   assign tx_sum = tx_acc + DW'(`UIB_FRAC_STEP);
   assign rx_sum = rx_acc + DW'(`UIB_FRAC_STEP);
   assign tx_tick = presc_tick & (tx_sum >= div);
   assign rx_tick = presc_tick & (rx_sum >= div);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_cnt <= 7'h0;
         tx_acc <= '0;
         rx_acc <= '0;
      end else begin
         presc_cnt <= presc_tick ? 7'h0 : presc_cnt + 7'h1;
         if (presc_tick) tx_acc <= tx_tick ? tx_sum - div : tx_sum;
         // restart at half a bit so samples land mid-bit
         if (rx_start) rx_acc <= div >> 1;
         else if (presc_tick) rx_acc <= rx_tick ? rx_sum - div : rx_sum;
      end
   end

   //------------------------------------------------------------
   // transmitter
   //------------------------------------------------------------
   uib_state_t tx_st_r;
   logic [7:0] tx_sh_r;
   logic [2:0] tx_bit_r;
   logic tx_par_r;
   assign tx_pop = tx_tick & (tx_st_r == UIB_IDLE) & en_r & ~brk_r & cts_ok
      & (tx_cnt != '0) & ~tx_clr; // R21

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st_r <= UIB_IDLE;
         tx_sh_r <= 8'h0;
         tx_bit_r <= 3'h0;
         tx_par_r <= 1'b0;
         txd_out <= 1'b1;
      end else if (tx_tick) begin
         unique case (tx_st_r)
            UIB_IDLE: begin
               txd_out <= ~brk_r;
               if (tx_pop) begin
                  tx_sh_r <= tx_mem[tx_rp];
                  tx_par_r <= ^tx_mem[tx_rp] ^ par_odd_r;
                  txd_out <= 1'b0;
                  tx_st_r <= UIB_START;
               end
            end
            UIB_START: begin
               txd_out <= tx_sh_r[0];
               tx_sh_r <= tx_sh_r >> 1;
               tx_bit_r <= 3'h0;
               tx_st_r <= UIB_DATA;
            end
            UIB_DATA: begin
               tx_bit_r <= tx_bit_r + 3'h1;
               if (tx_bit_r == 3'h7) begin
                  txd_out <= par_en_r ? tx_par_r : 1'b1;
                  tx_st_r <= par_en_r ? UIB_PAR : UIB_STOP;
               end else begin
                  txd_out <= tx_sh_r[0];
                  tx_sh_r <= tx_sh_r >> 1;
               end
            end
            UIB_PAR: begin
               txd_out <= 1'b1;
               tx_st_r <= UIB_STOP;
            end
            UIB_STOP: tx_st_r <= UIB_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // receiver
   //------------------------------------------------------------
   uib_state_t rx_st_r;
   logic [2:0] rx_bit_r;
   logic rx_pb_r, in_brk_r, is_brk;
   logic ev_frame, ev_par, ev_first, ev_last;
   assign rx_start = (rx_st_r == UIB_IDLE) & en_r & rxd_q & ~rxd_s2;
   assign is_brk = (rx_sh_r == 8'h0) & ~rxd_s2 & ~(par_en_r & rx_pb_r);

   always_comb begin
      rx_done = 1'b0;
      ev_frame = 1'b0;
      ev_par = 1'b0;
      ev_first = 1'b0;
      ev_last = (rx_st_r == UIB_IDLE) & in_brk_r & rxd_s2; // R7
      if (rx_tick & (rx_st_r == UIB_START)) ev_frame = rxd_s2; // R5
      if (rx_tick & (rx_st_r == UIB_STOP)) begin
         if (is_brk) begin
            ev_first = ~in_brk_r; // R7
         end else begin
            rx_done = 1'b1;
            ev_frame = ~rxd_s2; // R5
            ev_par = par_en_r & (rx_pb_r != (^rx_sh_r ^ par_odd_r)); // R5
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st_r <= UIB_IDLE;
         rx_sh_r <= 8'h0;
         rx_bit_r <= 3'h0;
         rx_pb_r <= 1'b0;
         in_brk_r <= 1'b0;
      end else begin
         if (ev_last) in_brk_r <= 1'b0;
         if (ev_first) in_brk_r <= 1'b1;
         if (rx_start) rx_st_r <= UIB_START;
         else if (rx_tick) begin
            unique case (rx_st_r)
               UIB_IDLE: ;
               UIB_START: begin
                  rx_bit_r <= 3'h0;
                  rx_st_r <= rxd_s2 ? UIB_IDLE : UIB_DATA;
               end
               UIB_DATA: begin
                  rx_sh_r <= {rxd_s2, rx_sh_r[7:1]};
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == 3'h7) rx_st_r <= par_en_r ? UIB_PAR : UIB_STOP;
               end
               UIB_PAR: begin
                  rx_pb_r <= rxd_s2;
                  rx_st_r <= UIB_STOP;
               end
               UIB_STOP: rx_st_r <= UIB_IDLE;
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // receive timeout in frame times
   //------------------------------------------------------------
   logic [3:0] fr_bit_r, fr_len;
   logic [8:0] fr_cnt_r, fr_lim;
   logic ev_to;
   assign fr_len = `UIB_FRAME_BITS + {3'h0, par_en_r};
   assign fr_lim = (idle_frame_limit_r == 8'h0) ? `UIB_LIMIT_ZERO
      : {1'b0, idle_frame_limit_r}; // R23
   assign ev_to = tx_tick & (fr_bit_r == fr_len - 4'h1) & (fr_cnt_r + 9'h1 == fr_lim); // R6

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fr_bit_r <= 4'h0;
         fr_cnt_r <= 9'h0;
      end else if (rx_push | rx_pop | (rx_cnt == '0) | rx_clr) begin
         fr_bit_r <= 4'h0;
         fr_cnt_r <= 9'h0;
      end else if (tx_tick) begin
         if (fr_bit_r == fr_len - 4'h1) begin
            fr_bit_r <= 4'h0;
            if (fr_cnt_r != 9'h1ff) fr_cnt_r <= fr_cnt_r + 9'h1;
         end else begin
            fr_bit_r <= fr_bit_r + 4'h1;
         end
      end
   end

   //------------------------------------------------------------
   // sticky event flags, write one to clear, set wins
   //------------------------------------------------------------
   always_comb begin
      set_v.tx_lvl = tx_cnt <= tx_thr_r; // R1
      set_v.rx_lvl = rx_cnt >= rx_thr_r; // R2
      set_v.overrun = rx_done & (rx_cnt == FULL); // R3
      set_v.cts = flow_r & (cts_s2 != cts_q); // R4
      set_v.parity = ev_par;
      set_v.frame = ev_frame;
      set_v.timeout = ev_to;
      set_v.brk_first = ev_first;
      set_v.brk_last = ev_last;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) flags_r <= '0;
      else if (wr & (wa == `UIB_OFS_FLAGS)) flags_r <= (flags_r & ~avs_writedata[8:0]) | set_v;
      else flags_r <= flags_r | set_v;
   end

   //------------------------------------------------------------
   // transfer requests and rts
   //------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_dma_req <= 1'b0;
         rx_dma_req <= 1'b0;
         rts_out <= 1'b1;
      end else begin
         tx_dma_req <= txdma_en_r & (tx_cnt < txdma_lvl_r); // R12 R13 R16
         rx_dma_req <= rxdma_en_r & (rx_cnt > rxdma_lvl_r); // R12 R13 R14
         if (flow_r & (rx_cnt >= rts_lvl_r)) rts_out <= ~fpol_r; // R22 R24
         else rts_out <= fpol_r; // R20 R25
      end
   end

   always_comb begin
      unique case (wa)
         `UIB_OFS_CTRL0: rd_mux = {8'h0, idle_frame_limit_r, 3'h0, fpol_r, flow_r, 7'h0,
            brk_r, par_odd_r, par_en_r, en_r};
         `UIB_OFS_CTRL1: rd_mux = {10'h0, rts_lvl_r, 2'h0, tx_thr_r, 2'h0, rx_thr_r};
         `UIB_OFS_STAT: rd_mux = {13'h0, cts_ok, rx_st_r != UIB_IDLE, tx_st_r != UIB_IDLE,
            2'h0, tx_cnt, 2'h0, rx_cnt};
         `UIB_OFS_FLAGS: rd_mux = {23'h0, flags_r};
         `UIB_OFS_RATE_INT: rd_mux = {13'h0, presc_sel_r, 4'h0, ibaud_r};
         `UIB_OFS_RATE_FRAC: rd_mux = {25'h0, dbaud_r};
         `UIB_OFS_DATA: rd_mux = {24'h0, rx_mem[rx_rp]};
         `UIB_OFS_XFER: rd_mux = {16'h0, rxdma_en_r, 1'b0, rxdma_lvl_r, txdma_en_r, 1'b0,
            txdma_lvl_r};
         default: rd_mux = 32'h0;
      endcase
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   AST_TX_DMA: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (txdma_en_r && tx_cnt < txdma_lvl_r) |=> tx_dma_req) else $error("tx request missing");
   AST_RX_DMA: assert property (@(posedge clk) disable iff (sys_rst) // R14
      (!rxdma_en_r || rx_cnt <= rxdma_lvl_r) |=> !rx_dma_req) else $error("rx request spurious");
   AST_TX_LVL: assert property (@(posedge clk) disable iff (sys_rst) // R1
      (tx_cnt <= tx_thr_r) |=> flags_r.tx_lvl) else $error("tx level flag missing");
   AST_RX_LVL: assert property (@(posedge clk) disable iff (sys_rst) // R2
      (rx_cnt >= rx_thr_r) |=> flags_r.rx_lvl) else $error("rx level flag missing");
   AST_OVERRUN: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (rx_done && rx_cnt == FULL && !rx_clr) |=> flags_r.overrun && $stable(rx_wp))
      else $error("overrun lost");
   AST_CTS_CHG: assert property (@(posedge clk) disable iff (sys_rst) // R4
      (flow_r && $changed(cts_s2)) |-> ##1 flags_r.cts) else $error("cts change not flagged");
   AST_FLUSH: assert property (@(posedge clk) disable iff (sys_rst) // R18
      (wr && wa == `UIB_OFS_CTRL0 && avs_writedata[`UIB_C0_RXFL]) |=> rx_cnt == '0)
      else $error("rx flush failed");
   AST_DISABLE: assert property (@(posedge clk) disable iff (sys_rst) // R19
      !en_r |=> (tx_cnt == '0 && rx_cnt == '0)) else $error("disable did not flush");
   AST_RTS: assert property (@(posedge clk) disable iff (sys_rst) // R22
      (flow_r && rx_cnt >= rts_lvl_r) |=> rts_out == ~$past(fpol_r))
      else $error("rts not dropped");
   AST_CTS_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R21
      (tx_st_r == UIB_IDLE && !cts_ok) |=> tx_st_r == UIB_IDLE) else $error("sent without cts");
   AST_PRESC: assert property (@(posedge clk) disable iff (sys_rst) // R8
      (presc_cnt <= (7'h7f >> presc_sel_r))
      |-> (presc_tick == (presc_cnt == (7'h7f >> presc_sel_r))))
      else $error("prescale count wrong");
endmodule

// [uib_remote.sv]
// remote serial port model that waits for rts before sending, cts driven by the bench
`timescale 1ns/1ns
module uib_remote #(
   parameter int BIT_CLKS = 4
) (
   input wire logic clk, // system clock
   input wire logic txd_line, // device transmit pin
   input wire logic rts_line, // device request-to-send
   input wire logic flow_on, // wait for rts before sending
   input wire logic pol, // asserted handshake level
   output logic rxd_line // drives device receive pin
);
   initial rxd_line = 1'b1;
   // waits that ran out of time, read by the bench before its verdict
   int misses = 0;
   //------------------------------------------------------------
   // send one frame lsb first, stop level chosen by caller
   //------------------------------------------------------------
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      int n;
      begin
         f = {stop, d, 1'b0};
         n = 0;
         while (flow_on && rts_line !== pol && n < 2000) begin
            @(posedge clk);
            n++;
         end
         if (n == 2000) misses++;
         for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd_line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
         end
         @(posedge clk);
         rxd_line <= 1'b1;
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask
   //------------------------------------------------------------
   // receive one frame, unknown data if none starts
   //------------------------------------------------------------
   task automatic recv(output logic [7:0] d);
      int n;
      begin
         d = 8'hxx;
         n = 0;
         while (txd_line !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
         end
         if (n < 3000) begin
            repeat (BIT_CLKS / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CLKS) @(posedge clk);
               d[i] = txd_line;
            end
            repeat (BIT_CLKS) @(posedge clk);
         end else begin
            misses++;
         end
      end
   endtask
endmodule

// [tb_uart_irq_baud_dma_flow.sv]
// self-checking testbench for the serial port block
`timescale 1ns/1ns
`include "uib_consts.svh"
module tb_uart_irq_baud_dma_flow;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rxd, txd, rts_out, tx_q, rx_q;
   logic cts_in = 1'b0;
   logic flow_on = 1'b0;
   logic pol = 1'b0;
   logic [7:0] b;
   int fail_count = 0;
   int compares = 0;
   always #5 clk = ~clk;
   uib_top u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_in(rxd),
      .cts_in(cts_in), .txd_out(txd), .rts_out(rts_out), .tx_dma_req(tx_q),
      .rx_dma_req(rx_q));
   uib_remote #(.BIT_CLKS(4)) u_rem (.clk(clk), .txd_line(txd), .rts_line(rts_out),
      .flow_on(flow_on), .pol(pol), .rxd_line(rxd));
   //------------------------------------------------------------
   // reporting and bus access
   //------------------------------------------------------------
   task automatic print_verdict;
      begin
         $display("compares %0d mismatches %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         compares++;
         if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      begin
         @(posedge clk);
         avs_address <= a;
         avs_write <= w;
         avs_read <= !w;
         avs_writedata <= wd;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (avs_waitrequest !== 1'b0 && n < 20);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            print_verdict();
         end
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      begin
         bus(1'b1, a, d, x);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      begin
         bus(1'b0, a, 32'h0, x);
         check(x & m, e);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      waitc(3);
      check({28'h0, txd, rts_out, tx_q, rx_q}, 32'h8);
      rd_chk(6'h0c, 32'hffffffff, 32'h0);
      wr(`UIB_OFS_RATE_INT, 32'h0007_0004);
      wr(`UIB_OFS_RATE_FRAC, 32'h0);
      wr(`UIB_OFS_CTRL1, 32'h0002_0001);
      wr(`UIB_OFS_XFER, 32'h0000_8082);
      wr(`UIB_OFS_CTRL0, 32'h1);
      // rx level flag latched while the threshold was still zero
      wr(`UIB_OFS_FLAGS, 32'h1ff);
      waitc(3);
      check({30'h0, tx_q, rx_q}, 32'h2);
      rd_chk(`UIB_OFS_FLAGS, 32'h3, 32'h1);
      u_rem.send(8'ha5, 1'b1);
      waitc(4);
      check({31'h0, rx_q}, 32'h1);
      rd_chk(`UIB_OFS_FLAGS, 32'h2, 32'h2);
      rd_chk(`UIB_OFS_STAT, 32'h3f, 32'h1);
      rd_chk(`UIB_OFS_DATA, 32'hff, 32'ha5);
      waitc(3);
      check({31'h0, rx_q}, 32'h0);
      u_rem.send(8'h3c, 1'b0);
      waitc(4);
      rd_chk(`UIB_OFS_FLAGS, 32'h60, 32'h20);
      wr(`UIB_OFS_FLAGS, 32'h1ff);
      rd_chk(`UIB_OFS_FLAGS, 32'h20, 32'h0);
      waitc(10000);
      rd_chk(`UIB_OFS_FLAGS, 32'h40, 32'h0);
      waitc(800);
      rd_chk(`UIB_OFS_FLAGS, 32'h40, 32'h40);
      // break: zero data with low stop, then line returns high
      u_rem.send(8'h00, 1'b0);
      waitc(4);
      rd_chk(`UIB_OFS_FLAGS, 32'h1a0, 32'h180);
      // even parity on, remote's stop slot carries a wrong parity bit
      wr(`UIB_OFS_CTRL0, 32'h3);
      u_rem.send(8'h01, 1'b0);
      waitc(4);
      rd_chk(`UIB_OFS_FLAGS, 32'h30, 32'h10);
      wr(`UIB_OFS_CTRL0, 32'h11);
      rd_chk(`UIB_OFS_STAT, 32'h3f, 32'h0);
      for (int i = 0; i < 33; i++) begin
         if (i == 32) rd_chk(`UIB_OFS_FLAGS, 32'h4, 32'h0);
         u_rem.send(i[7:0], 1'b1);
      end
      waitc(4);
      rd_chk(`UIB_OFS_STAT, 32'h3f, 32'h20);
      rd_chk(`UIB_OFS_FLAGS, 32'h4, 32'h4);
      flow_on <= 1'b1;
      pol <= 1'b1;
      wr(`UIB_OFS_CTRL0, 32'h1811);
      waitc(3);
      check({31'h0, rts_out}, 32'h1);
      u_rem.send(8'h01, 1'b1);
      u_rem.send(8'h02, 1'b1);
      waitc(4);
      check({31'h0, rts_out}, 32'h0);
      rd_chk(`UIB_OFS_DATA, 32'hff, 32'h01);
      waitc(3);
      check({31'h0, rts_out}, 32'h1);
      wr(`UIB_OFS_CTRL0, 32'h1811);
      wr(`UIB_OFS_RATE_INT, 32'h0006_0002);
      wr(`UIB_OFS_FLAGS, 32'h1ff);
      wr(`UIB_OFS_DATA, 32'h5a);
      waitc(60);
      rd_chk(`UIB_OFS_STAT, 32'h3f00, 32'h100);
      cts_in <= 1'b1;
      u_rem.recv(b);
      check({24'h0, b}, 32'h5a);
      rd_chk(`UIB_OFS_FLAGS, 32'h8, 32'h8);
      wr(`UIB_OFS_FLAGS, 32'h1ff);
      cts_in <= 1'b0;
      waitc(5);
      rd_chk(`UIB_OFS_FLAGS, 32'h8, 32'h8);
      flow_on <= 1'b0;
      wr(`UIB_OFS_CTRL0, 32'h1);
      wr(`UIB_OFS_DATA, 32'h33);
      u_rem.recv(b);
      check({24'h0, b}, 32'h33);
      flow_on <= 1'b1;
      wr(`UIB_OFS_CTRL0, 32'h1801);
      u_rem.send(8'h44, 1'b1);
      wr(`UIB_OFS_DATA, 32'h11);
      wr(`UIB_OFS_DATA, 32'h22);
      rd_chk(`UIB_OFS_STAT, 32'h3f3f, 32'h201);
      wr(`UIB_OFS_CTRL0, 32'h0);
      rd_chk(`UIB_OFS_STAT, 32'h3f3f, 32'h0);
      check(u_rem.misses, 32'h0);
      print_verdict();
   end
endmodule
